// ---- bench/boost_stage_model.sv ----
// Behavioural boost stage and LED strings beside the supervisor.
`timescale 1ns/1ps
module boost_stage_model (
  input wire logic i_clock,
  input wire logic i_gate_en,
  input wire logic i_disc_en,
  input wire logic [5:0] i_sink_en,
  input wire logic [5:0] i_open,
  input wire logic i_surge,
  output logic [5:0] o_in_reg,
  output logic o_ovp,
  output logic o_rearm,
  output logic o_greq
);
  logic [3:0] v_r = 4'h0;
  // The supply reaches the stage only through the disconnect switch.
  always_ff @(posedge i_clock) begin
    if (!i_disc_en) begin
      v_r <= 4'h0;
    end else if (i_gate_en) begin
      v_r <= v_r + {3'h0, v_r != 4'hF};
    end else begin
      v_r <= v_r - {3'h0, v_r != 4'h0};
    end
  end
  // An open string never regulates, so the modulator boosts into the limit.
  assign o_in_reg = i_sink_en & ~i_open & {6{v_r[3]}};
  assign o_greq = v_r < 4'h9 || |(i_sink_en & ~o_in_reg);
  assign o_ovp = &v_r || i_surge;
  assign o_rearm = v_r < 4'hC;
endmodule : boost_stage_model

// ---- bench/fault_sup_chk.sv ----
// Concurrent checks on the fault supervisor pins.
`timescale 1ns/1ps
module fault_sup_chk #(
  parameter int unsigned CLEAR_CYCLES = 50
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_enable,
  input wire logic i_dimming,
  input wire logic i_overvoltage_sense,
  input wire logic i_primary_current_limit,
  input wire logic i_secondary_current_limit,
  input wire logic i_input_current_sense,
  input wire logic i_gate_request,
  input wire logic o_gate_en,
  input wire logic [5:0] o_sink_en,
  input wire logic o_disconnect_gate_en,
  input wire logic o_fault_n_o,
  input wire logic o_fault_n_oe
);
  localparam int OC_MAX = 375;
  logic [31:0] low_r;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  // Pin cycles with enable or dimming low; the synchroniser lag keeps this ahead of the design.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n || (i_enable && i_dimming)) begin
      low_r <= 32'h0;
    end else if (low_r <= CLEAR_CYCLES) begin
      low_r <= low_r + 32'h1;
    end
  end
  sequence hard_off;
    !o_disconnect_gate_en && o_sink_en == 6'h00 && o_fault_n_oe;
  endsequence
  sequence latched_hold;
    (o_fault_n_oe && !o_disconnect_gate_en && i_enable && i_dimming) [*6];
  endsequence
  a_primary_cuts_gate: assert property (i_primary_current_limit |-> !o_gate_en)
    else $error("gate on at primary limit");
  a_gate_needs_request: assert property (o_gate_en |-> i_gate_request)
    else $error("gate on without request");
  a_ovp_stops_gate: assert property (i_overvoltage_sense [*6] |-> !o_gate_en)
    else $error("gate on in overvoltage");
  a_secondary_shuts_down: assert property (i_secondary_current_limit [*4] |-> ##[0:4] hard_off)
    else $error("no secondary shutdown");
  a_input_oc_fast: assert property ($rose(i_input_current_sense) |-> ##[1:OC_MAX] hard_off)
    else $error("input trip too slow");
  a_latch_holds: assert property (latched_hold |=> o_fault_n_oe)
    else $error("latch left early");
  a_alarm_pulls_low: assert property (o_fault_n_oe |-> !o_fault_n_o)
    else $error("alarm not driven low");
  a_clear_needs_low: assert property ($fell(o_fault_n_oe) |-> low_r >= CLEAR_CYCLES)
    else $error("alarm cleared too soon");
endmodule : fault_sup_chk
bind led_boost_fault_supervisor fault_sup_chk #(.CLEAR_CYCLES(CLEAR_CYCLES)) u_chk (.*);

// ---- bench/tb_led_boost_fault_supervisor.sv ----
// Self-checking bench for the LED boost fault supervisor.
`timescale 1ns/1ps
module tb_led_boost_fault_supervisor;
  localparam int CLR = 50;
  logic i_clock = 1'b0, i_rst_n = 1'b0, i_wb_cyc = 1'b0, i_wb_stb = 1'b0, i_wb_we = 1'b0;
  logic i_enable = 1'b0, i_dimming = 1'b0, i_supply_rise_threshold = 1'b0;
  logic i_supply_fall_threshold = 1'b0, i_primary_current_limit = 1'b0;
  logic i_secondary_current_limit = 1'b0, i_input_current_sense = 1'b0, surge = 1'b0;
  logic [7:0] i_wb_adr = 8'h00;
  logic [3:0] i_wb_sel = 4'h0;
  logic [31:0] i_wb_dat = 32'h0, o_wb_dat, rd;
  logic [5:0] open_r = 6'h00, i_string_in_reg, o_sink_en;
  logic o_wb_ack, o_irq, i_overvoltage_sense, i_ovp_rearm, i_gate_request, o_gate_en;
  logic o_disconnect_gate_en, o_fault_n_o, o_fault_n_oe;
  logic [5:0] sink2, in_reg2;
  logic gate2, disc2, oe2, ovp2, rearm2, greq2;
  wire logic i_fault_n_i = o_fault_n_oe ? o_fault_n_o : 1'b1;
  int err_count = 0, comparisons = 0;
  initial begin
    forever #4 i_clock = ~i_clock;
  end
  led_boost_fault_supervisor #(.UVLO_CYCLES(20), .CLEAR_CYCLES(CLR)) dut (.*);
  boost_stage_model u_stage (.i_clock(i_clock), .i_gate_en(o_gate_en),
    .i_disc_en(o_disconnect_gate_en), .i_sink_en(o_sink_en), .i_open(open_r), .i_surge(surge),
    .o_in_reg(i_string_in_reg), .o_ovp(i_overvoltage_sense), .o_rearm(i_ovp_rearm),
    .o_greq(i_gate_request));
  // The all-out build shares clock, reset, enable, dimming, supply and limit inputs, but not its power stage, fault pin or bus, so both see one stimulus.
  led_boost_fault_supervisor #(.ALL_OUT(1'b1), .UVLO_CYCLES(20), .CLEAR_CYCLES(CLR)) dut_all (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_wb_cyc(1'b0), .i_wb_stb(1'b0), .i_wb_we(1'b0),
    .i_wb_adr(8'h00), .i_wb_sel(4'h0), .i_wb_dat(32'h0000_0000), .o_wb_dat(), .o_wb_ack(),
    .o_irq(), .i_enable(i_enable), .i_dimming(i_dimming),
    .i_supply_rise_threshold(i_supply_rise_threshold),
    .i_supply_fall_threshold(i_supply_fall_threshold), .i_overvoltage_sense(ovp2),
    .i_ovp_rearm(rearm2), .i_primary_current_limit(i_primary_current_limit),
    .i_secondary_current_limit(i_secondary_current_limit),
    .i_input_current_sense(i_input_current_sense), .i_string_in_reg(in_reg2),
    .i_gate_request(greq2), .o_gate_en(gate2), .o_sink_en(sink2),
    .o_disconnect_gate_en(disc2), .i_fault_n_i(!oe2), .o_fault_n_o(), .o_fault_n_oe(oe2));
  boost_stage_model u_stage2 (.i_clock(i_clock), .i_gate_en(gate2), .i_disc_en(disc2),
    .i_sink_en(sink2), .i_open(open_r), .i_surge(surge), .o_in_reg(in_reg2), .o_ovp(ovp2),
    .o_rearm(rearm2), .o_greq(greq2));
  task automatic tally_and_finish();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic ck(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : ck
  task automatic hold(input int c);
    repeat (c) @(posedge i_clock);
  endtask : hold
  // One classic cycle; the strobe drops for a cycle before the next request.
  task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d);
    hold(1);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we <= w;
    i_wb_sel <= 4'hF;
    i_wb_adr <= a;
    i_wb_dat <= d;
    while (o_wb_ack !== 1'b1) hold(1);
    rd = o_wb_dat;
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
  endtask : xf
  task automatic ws(input logic [1:0] s);
    int n;
    n = 0;
    do begin
      xf(1'b0, fault_pkg::ADR_STATE, 32'h0);
      n++;
    end while (rd[11:10] !== s && n < 200);
    ck({30'h0, rd[11:10]}, {30'h0, s});
  endtask : ws
  task automatic wg();
    int n;
    for (n = 0; n < 300 && o_gate_en !== 1'b1; n++) hold(1);
    ck({31'h0, o_gate_en}, 32'h1);
  endtask : wg
  initial begin
    hold(20000);
    err_count++;
    tally_and_finish();
  end
  initial begin
    int n;
    hold(6);
    i_rst_n <= 1'b1;
    xf(1'b0, fault_pkg::ADR_CTRL, 32'h0);
    ck(rd, 32'h1);
    xf(1'b0, 8'h10, 32'h0);
    ck(rd, 32'h0);
    xf(1'b1, fault_pkg::ADR_MASK, 32'h20);
    open_r <= 6'h01;
    i_supply_rise_threshold <= 1'b1;
    i_enable <= 1'b1;
    i_dimming <= 1'b1;
    ws(fault_pkg::ST_RUN);
    ck({25'h0, i_fault_n_i, o_sink_en}, 32'h3E);
    ck({24'h0, oe2, disc2, sink2}, 32'h80);
    xf(1'b0, fault_pkg::ADR_STATUS, 32'h0);
    ck({24'h0, o_irq, rd[6:0]}, 32'h11);
    wg();
    open_r <= 6'h00;
    i_dimming <= 1'b0;
    hold(CLR / 2);
    i_dimming <= 1'b1;
    hold(8);
    ck({31'h0, o_fault_n_oe}, 32'h1);
    ck({31'h0, oe2}, 32'h1);
    i_dimming <= 1'b0;
    hold(CLR + 10);
    i_dimming <= 1'b1;
    ck({31'h0, o_fault_n_oe}, 32'h0);
    ws(fault_pkg::ST_RUN);
    ck({26'h0, o_sink_en}, 32'h3F);
    ck({26'h0, sink2}, 32'h3F);
    wg();
    i_primary_current_limit <= 1'b1;
    @(negedge i_clock);
    ck({31'h0, o_gate_en}, 32'h0);
    hold(1);
    i_primary_current_limit <= 1'b0;
    hold(8);
    ck({31'h0, o_fault_n_oe}, 32'h0);
    wg();
    surge <= 1'b1;
    hold(10);
    ck({24'h0, o_gate_en, o_fault_n_oe, o_sink_en}, 32'h3F);
    surge <= 1'b0;
    wg();
    open_r <= 6'h08;
    hold(40);
    ck({25'h0, o_disconnect_gate_en, o_sink_en}, 32'h77);
    ck({24'h0, oe2, disc2, sink2}, 32'h80);
    wg();
    open_r <= 6'h00;
    i_dimming <= 1'b0;
    hold(CLR + 10);
    i_dimming <= 1'b1;
    ws(fault_pkg::ST_RUN);
    i_supply_fall_threshold <= 1'b1;
    hold(12);
    i_supply_fall_threshold <= 1'b0;
    hold(8);
    ck({31'h0, o_irq}, 32'h0);
    ws(fault_pkg::ST_RUN);
    i_supply_rise_threshold <= 1'b0;
    i_supply_fall_threshold <= 1'b1;
    hold(40);
    ck({25'h0, o_irq, o_sink_en}, 32'h40);
    ws(fault_pkg::ST_OFF);
    xf(1'b1, fault_pkg::ADR_STATUS, 32'h7F);
    hold(3);
    ck({31'h0, o_irq}, 32'h0);
    i_supply_fall_threshold <= 1'b0;
    i_supply_rise_threshold <= 1'b1;
    ws(fault_pkg::ST_RUN);
    i_secondary_current_limit <= 1'b1;
    hold(6);
    i_secondary_current_limit <= 1'b0;
    hold(4);
    ck({25'h0, o_disconnect_gate_en, o_sink_en}, 32'h0);
    hold(20);
    ws(fault_pkg::ST_LATCH);
    i_enable <= 1'b0;
    hold(CLR + 10);
    i_enable <= 1'b1;
    ck({31'h0, o_fault_n_oe}, 32'h0);
    wg();
    i_input_current_sense <= 1'b1;
    for (n = 0; n < 400 && o_disconnect_gate_en !== 1'b0; n++) hold(1);
    ck({31'h0, n <= 375}, 32'h1);
    ck({31'h0, i_fault_n_i}, 32'h0);
    i_input_current_sense <= 1'b0;
    ws(fault_pkg::ST_LATCH);
    tally_and_finish();
  end
endmodule : tb_led_boost_fault_supervisor

// ---- hw/fault_pkg.sv ----
// Constants, field layouts and types for the LED boost fault supervisor.
// Function
// R01: Overvoltage alone stops switching, no latch, no alarm.
// R02: Startup overvoltage drops unregulated strings, alarms, stops switching.
// R03: Continue variant resumes once output has fallen.
// R04: All-out variant startup overvoltage latches everything off.
// R05: Running overvoltage removes the currentless string only.
// R06: All-out variant open string latches all off.
// R07: Primary limit ends on-time at once, no flag.
// R08: Secondary limit shuts down and latches off.
// R09: Input overcurrent shuts down fast, alarms, latches.
// R10: Input overcurrent turns disconnect switch gate off.
// R11: Supply rise enables; long supply fall disables.
// R12: All fault inputs are monitored during operation.
// R13: String loss is masked during startup transients.
// R14: System fits the disconnect switch for shorts.
// R15: Enable or dimming low 16 ms clears faults.
// R16: Alarm is active-low open-drain, wired-AND capable.
// R17: Comparator flags synchronised, primary limit excepted.
// R18: Build option selects continue or all-out behaviour.
package fault_pkg;
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned UVLO_FALL_NS = 50000;
  localparam int unsigned FAULT_CLR_NS = 16000000;
  localparam int unsigned INPUT_OC_MAX_NS = 3000;
  // Least times round up to whole cycles, longest times round down.
  localparam int unsigned UVLO_FALL_CYC = (UVLO_FALL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FAULT_CLR_CYC = (FAULT_CLR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned INPUT_OC_MAX_CYC = INPUT_OC_MAX_NS / CLK_PERIOD_NS;

  localparam int unsigned NUM_STRINGS = 6;
  localparam int unsigned SYNC_W = 16;

  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_MASK = 8'h08;
  localparam logic [7:0] ADR_STATE = 8'h0C;

  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam logic CTRL_RUN_RESET = 1'h1;

  localparam int unsigned EV_W = 7;
  localparam int unsigned EV_OVP = 0;
  localparam int unsigned EV_PRIMARY = 1;
  localparam int unsigned EV_SECONDARY = 2;
  localparam int unsigned EV_INPUT_OC = 3;
  localparam int unsigned EV_STRING = 4;
  localparam int unsigned EV_UVLO = 5;
  localparam int unsigned EV_CLEAR = 6;
  localparam logic [6:0] STATUS_RESET = 7'h00;
  localparam logic [6:0] MASK_RESET = 7'h00;

  localparam int unsigned ST_STRINGS_LSB = 0;
  localparam int unsigned ST_ALARM = 6;
  localparam int unsigned ST_SUPPLY_OK = 7;
  localparam int unsigned ST_FAULT_PIN = 8;
  localparam int unsigned ST_OVP_STOP = 9;
  localparam int unsigned ST_STATE_LSB = 10;

  typedef enum logic [1:0] {
    ST_OFF,
    ST_SOFT,
    ST_RUN,
    ST_LATCH
  } sup_state_t;

  // Write-one-to-clear update in which a new event wins over a clear.
  function automatic logic [6:0] w1c_update(input logic [6:0] cur, input logic [6:0] set,
                                            input logic [6:0] clr);
    w1c_update = (cur & ~clr) | set;
  endfunction : w1c_update
endpackage : fault_pkg

// ---- hw/led_boost_fault_supervisor.sv ----
// Fault supervisor for a boost LED driver with a Wishbone register port.
//
// Added by the designer: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
module led_boost_fault_supervisor #(
  parameter bit ALL_OUT = 1'b0,
  parameter int unsigned UVLO_CYCLES = fault_pkg::UVLO_FALL_CYC,
  parameter int unsigned CLEAR_CYCLES = fault_pkg::FAULT_CLR_CYC
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  output logic o_irq,
  input wire logic i_enable,
  input wire logic i_dimming,
  input wire logic i_supply_rise_threshold,
  input wire logic i_supply_fall_threshold,
  input wire logic i_overvoltage_sense,
  input wire logic i_ovp_rearm,
  input wire logic i_primary_current_limit,
  input wire logic i_secondary_current_limit,
  input wire logic i_input_current_sense,
  input wire logic [5:0] i_string_in_reg,
  input wire logic i_gate_request,
  output logic o_gate_en,
  output logic [5:0] o_sink_en,
  output logic o_disconnect_gate_en,
  input wire logic i_fault_n_i,
  output logic o_fault_n_o,
  output logic o_fault_n_oe
);
  logic [15:0] raw_in;
  logic [15:0] syn;
  logic en_s;
  logic dim_s;
  logic rise_s;
  logic fall_s;
  logic ovp_s;
  logic rearm_s;
  logic sec_s;
  logic ioc_s;
  logic prim_s;
  logic pin_s;
  logic [5:0] reg_s;

  fault_pkg::sup_state_t state_r;
  fault_pkg::sup_state_t state_nxt;
  logic alarm_r;
  logic alarm_nxt;
  logic [5:0] string_off_r;
  logic [5:0] string_off_nxt;
  logic ovp_stop_r;
  logic supply_ok_r;
  logic [31:0] fall_cnt_r;
  logic [31:0] clr_cnt_r;
  logic fault_clear;
  logic uvlo_trip;
  logic active;
  logic hard_trip;
  logic ovp_prev_r;
  logic prim_prev_r;
  logic [5:0] unreg;
  logic switch_allow_r;
  logic ctrl_run_r;
  logic [6:0] status_r;
  logic [6:0] mask_r;
  logic [6:0] ev_set;
  logic [6:0] ev_clr;
  logic wb_req;
  logic wb_wr;
  logic [31:0] rd_data;

  // The primary limit is synchronised only for the event flag; the gate uses it raw.
  assign raw_in = {i_enable, i_dimming, i_supply_rise_threshold, i_supply_fall_threshold,
                   i_overvoltage_sense, i_ovp_rearm, i_secondary_current_limit,
                   i_input_current_sense, i_primary_current_limit, i_fault_n_i,
                   i_string_in_reg};

  sync3 #(
    .W(fault_pkg::SYNC_W)
  ) u_sync (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_async(raw_in),
    .o_sync(syn)
  ); // R17 R12

  assign en_s = syn[15];
  assign dim_s = syn[14];
  assign rise_s = syn[13];
  assign fall_s = syn[12];
  assign ovp_s = syn[11];
  assign rearm_s = syn[10];
  assign sec_s = syn[9];
  assign ioc_s = syn[8];
  assign prim_s = syn[7];
  assign pin_s = syn[6];
  assign reg_s = syn[5:0];

  // Supply monitor: rise enables, a fall must persist before disabling.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      fall_cnt_r <= 32'h0000_0000;
    end else if (fall_s && !uvlo_trip) begin
      fall_cnt_r <= fall_cnt_r + 32'h0000_0001;
    end else if (!fall_s) begin
      fall_cnt_r <= 32'h0000_0000;
    end
  end

  assign uvlo_trip = fall_s && (fall_cnt_r == 32'(UVLO_CYCLES)); // R11

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      supply_ok_r <= 1'b0;
    end else if (uvlo_trip) begin
      supply_ok_r <= 1'b0; // R11
    end else if (rise_s) begin
      supply_ok_r <= 1'b1; // R11
    end
  end

  // Fault clear: enable or dimming held low for longer than the clear time.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      clr_cnt_r <= 32'h0000_0000;
    end else if (en_s && dim_s) begin
      clr_cnt_r <= 32'h0000_0000;
    end else if (!fault_clear) begin
      clr_cnt_r <= clr_cnt_r + 32'h0000_0001;
    end
  end

  assign fault_clear = !(en_s && dim_s) && (clr_cnt_r == 32'(CLEAR_CYCLES)); // R15

  assign active = supply_ok_r && en_s && dim_s && ctrl_run_r;
  assign hard_trip = sec_s || ioc_s; // R08 R09 R10
  assign unreg = ~reg_s & ~string_off_r;

  always_comb begin
    state_nxt = state_r;
    alarm_nxt = alarm_r;
    string_off_nxt = string_off_r;
    if (fault_clear) begin
      state_nxt = fault_pkg::ST_OFF; // R15
      alarm_nxt = 1'b0;
      string_off_nxt = 6'h00;
    end else if (hard_trip && state_r != fault_pkg::ST_LATCH) begin
      state_nxt = fault_pkg::ST_LATCH; // R08 R09
      alarm_nxt = 1'b1;
    end else begin
      case (state_r)
        fault_pkg::ST_OFF: begin
          if (active) begin
            state_nxt = fault_pkg::ST_SOFT;
          end
        end
        fault_pkg::ST_SOFT: begin
          // Strings still rising are judged only at overvoltage, not before.
          if (!active) begin
            state_nxt = fault_pkg::ST_OFF;
          end else if (ovp_s && !ovp_prev_r && unreg != 6'h00) begin
            alarm_nxt = 1'b1; // R02 R13
            if (ALL_OUT) begin
              state_nxt = fault_pkg::ST_LATCH; // R04 R18
            end else begin
              string_off_nxt = string_off_r | unreg; // R02
              state_nxt = fault_pkg::ST_RUN;
            end
          end else if (unreg == 6'h00) begin
            state_nxt = fault_pkg::ST_RUN;
          end
        end
        fault_pkg::ST_RUN: begin
          if (!active) begin
            state_nxt = fault_pkg::ST_OFF;
          end else if (ovp_s && !ovp_prev_r && unreg != 6'h00) begin
            alarm_nxt = 1'b1;
            if (ALL_OUT) begin
              state_nxt = fault_pkg::ST_LATCH; // R06 R18
            end else begin
              string_off_nxt = string_off_r | unreg; // R05
            end
          end
        end
        fault_pkg::ST_LATCH: begin
          state_nxt = fault_pkg::ST_LATCH; // R04 R06
        end
        default: begin
          state_nxt = fault_pkg::ST_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      state_r <= fault_pkg::ST_OFF;
      alarm_r <= 1'b0;
      string_off_r <= 6'h00;
    end else begin
      state_r <= state_nxt;
      alarm_r <= alarm_nxt;
      string_off_r <= string_off_nxt;
    end
  end

  // Overvoltage stop: no latch, no alarm; resumes after the output has fallen.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      ovp_stop_r <= 1'b0;
    end else if (ovp_s) begin
      ovp_stop_r <= 1'b1; // R01
    end else if (rearm_s) begin
      ovp_stop_r <= 1'b0; // R03
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      ovp_prev_r <= 1'b0;
      prim_prev_r <= 1'b0;
    end else begin
      ovp_prev_r <= ovp_s;
      prim_prev_r <= prim_s;
    end
  end

  // Switching permission, sinks and the disconnect gate follow the next state.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      switch_allow_r <= 1'b0;
      o_sink_en <= 6'h00;
      o_disconnect_gate_en <= 1'b0;
    end else begin
      switch_allow_r <= (state_nxt == fault_pkg::ST_SOFT || state_nxt == fault_pkg::ST_RUN)
                        && !ovp_s && !(ovp_stop_r && !rearm_s); // R01 R02 R03
      if (state_nxt == fault_pkg::ST_SOFT || state_nxt == fault_pkg::ST_RUN) begin
        o_sink_en <= ~string_off_nxt; // R03 R05
      end else begin
        o_sink_en <= 6'h00; // R04 R06 R08
      end
      o_disconnect_gate_en <= active && !hard_trip && state_nxt != fault_pkg::ST_LATCH; // R10
    end
  end

  // The primary limit cuts the on-time combinationally, so no sync delay adds overshoot.
  assign o_gate_en = i_gate_request && switch_allow_r && !i_primary_current_limit; // R07

  // The alarm pin only ever pulls low, so several devices can share one line.
  assign o_fault_n_o = 1'b0; // R16
  assign o_fault_n_oe = alarm_r; // R16

  // Event capture for the interrupt; the primary limit flag is for software only.
  always_comb begin
    ev_set = 7'h00;
    ev_set[fault_pkg::EV_OVP] = ovp_s && !ovp_prev_r;
    ev_set[fault_pkg::EV_PRIMARY] = prim_s && !prim_prev_r;
    ev_set[fault_pkg::EV_SECONDARY] = sec_s && state_r != fault_pkg::ST_LATCH;
    ev_set[fault_pkg::EV_INPUT_OC] = ioc_s && state_r != fault_pkg::ST_LATCH;
    ev_set[fault_pkg::EV_STRING] = (string_off_nxt != string_off_r) ||
                                   (state_nxt == fault_pkg::ST_LATCH &&
                                    state_r != fault_pkg::ST_LATCH && !hard_trip);
    ev_set[fault_pkg::EV_UVLO] = uvlo_trip && supply_ok_r;
    ev_set[fault_pkg::EV_CLEAR] = fault_clear && (alarm_r || state_r == fault_pkg::ST_LATCH);
  end

  // Wishbone classic slave: ack one cycle after the request, write on the ack edge.
  assign wb_req = i_wb_cyc && i_wb_stb;
  assign wb_wr = wb_req && o_wb_ack && i_wb_we && i_wb_sel[0];

  always_comb begin
    ev_clr = 7'h00;
    if (wb_wr && i_wb_adr == fault_pkg::ADR_STATUS) begin
      ev_clr = i_wb_dat[6:0];
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_wb_ack <= 1'b0;
    end else begin
      o_wb_ack <= wb_req && !o_wb_ack;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      ctrl_run_r <= fault_pkg::CTRL_RUN_RESET;
      mask_r <= fault_pkg::MASK_RESET;
    end else if (wb_wr) begin
      if (i_wb_adr == fault_pkg::ADR_CTRL) begin
        ctrl_run_r <= i_wb_dat[fault_pkg::CTRL_RUN_BIT];
      end
      if (i_wb_adr == fault_pkg::ADR_MASK) begin
        mask_r <= i_wb_dat[6:0];
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      status_r <= fault_pkg::STATUS_RESET;
    end else begin
      status_r <= fault_pkg::w1c_update(status_r, ev_set, ev_clr);
    end
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    case (i_wb_adr)
      fault_pkg::ADR_CTRL: rd_data[fault_pkg::CTRL_RUN_BIT] = ctrl_run_r;
      fault_pkg::ADR_STATUS: rd_data[6:0] = status_r;
      fault_pkg::ADR_MASK: rd_data[6:0] = mask_r;
      fault_pkg::ADR_STATE: begin
        rd_data[fault_pkg::ST_STRINGS_LSB +: 6] = string_off_r;
        rd_data[fault_pkg::ST_ALARM] = alarm_r;
        rd_data[fault_pkg::ST_SUPPLY_OK] = supply_ok_r;
        rd_data[fault_pkg::ST_FAULT_PIN] = pin_s;
        rd_data[fault_pkg::ST_OVP_STOP] = ovp_stop_r;
        rd_data[fault_pkg::ST_STATE_LSB +: 2] = state_r;
      end
      default: rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_wb_dat <= 32'h0000_0000;
    end else if (wb_req && !o_wb_ack) begin
      o_wb_dat <= rd_data;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(status_r & mask_r);
    end
  end
endmodule : led_boost_fault_supervisor

// ---- hw/sync3.sv ----
// Three-stage synchroniser whose output follows once stages two and three agree.
`timescale 1ns/1ps
module sync3 #(
  parameter int unsigned W = 1
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] agree;

  assign agree = ~(s2_r ^ s3_r);

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= i_async;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // A single-cycle disagreement is treated as a glitch and ignored.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_sync <= '0;
    end else begin
      o_sync <= (agree & s3_r) | (~agree & o_sync);
    end
  end
endmodule : sync3
